// File: logic/fault_selftest_top.sv
// Purpose: Fault mask, fault latch, self-test sequencing and status over APB.
// Assumes: pclk 10 MHz; detector, cause, response and clear pins asynchronous.
// Notes:   Zero-wait APB slave; read data registered in the setup cycle.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "fault_regs.svh"
module fault_selftest_top
  import fault_pkg::*;
#(
  parameter int MASK_CYCLES = (`MASK_TIME_US * 1000) / `CLK_PERIOD_NS,
  parameter int ST_CYCLES = `ST_RUN_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fault_det_raw,
  input wire logic [2:0] fault_cause_raw,
  input wire logic st_resp_raw,
  input wire logic fault_clear_strobe_n,
  output logic live_fault,
  output logic latched_fault_flag,
  output logic [2:0] fault_cause_code,
  output logic loop_reset,
  output logic st_inject,
  output logic irq
);

  localparam int MCW = $clog2(MASK_CYCLES + 1);
  localparam int SCW = $clog2(ST_CYCLES + 1);

  // ==========================================================
  // Pin synchronisers
  pin_in_t pins_raw;
  pin_in_t pins_s;
  logic [$bits(pin_in_t)-1:0] pins_s_vec;

  assign pins_raw = '{clear_n: fault_clear_strobe_n, st_resp: st_resp_raw,
                      cause: fault_cause_raw, det: fault_det_raw};

  in_sync #(
    .W($bits(pin_in_t)),
    .RST_VAL(`PINS_RST)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(pins_raw),
    .q(pins_s_vec)
  );

  assign pins_s = pin_in_t'(pins_s_vec);

  // ==========================================================
  // Register decode helpers
  function automatic logic addr_valid(input logic [7:0] a);
    addr_valid = (a == `REG_CTRL) || (a == `REG_STATUS) ||
                 (a == `REG_IRQ_STAT) || (a == `REG_IRQ_MASK);
  endfunction : addr_valid

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] reg_off,
                                  input logic wr);
    wr_hit = wr && (a == reg_off);
  endfunction : wr_hit

  logic apb_wr;
  logic apb_rd_setup;

  assign apb_wr = psel && penable && pwrite && addr_valid(paddr);
  assign apb_rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_valid(paddr);

  // ==========================================================
  // Power-up mask timer
  logic [MCW-1:0] mask_cnt_q;
  logic [MCW-1:0] mask_cnt_d;
  logic mask_active;

  assign mask_active = (mask_cnt_q != MCW'(MASK_CYCLES));

  always_comb begin
    mask_cnt_d = mask_cnt_q;
    if (mask_active) begin
      mask_cnt_d = mask_cnt_q + MCW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_cnt_q <= '0;
    end else begin
      mask_cnt_q <= mask_cnt_d;
    end
  end

  // ==========================================================
  // Self-test sequencer
  st_state_t st_state_q;
  st_state_t st_state_d;
  logic [SCW-1:0] st_cnt_q;
  logic [SCW-1:0] st_cnt_d;
  logic [2:0] st_sel_q;
  logic [2:0] st_sel_d;
  logic [3:0] st_res_q;
  logic [3:0] st_res_d;
  logic st_done;
  logic st_start;
  logic [2:0] wr_sel;

  assign wr_sel = pwdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
  assign st_start = wr_hit(paddr, `REG_CTRL, apb_wr) && pwdata[`CTRL_START];

  always_comb begin
    st_state_d = st_state_q;
    st_cnt_d = st_cnt_q;
    st_sel_d = st_sel_q;
    st_res_d = st_res_q;
    st_done = 1'b0;
    unique case (st_state_q)
      ST_IDLE: begin
        if (wr_hit(paddr, `REG_CTRL, apb_wr)) begin
          st_sel_d = wr_sel;
        end
        if (st_start) begin
          if (wr_sel > `ST_SEL_LAST_VALID) begin
            st_res_d = `ST_RES_FAIL;
            st_done = 1'b1;
          end else begin
            st_res_d = `ST_RES_NONE;
            st_cnt_d = '0;
            st_state_d = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        st_cnt_d = st_cnt_q + SCW'(1);
        if (st_cnt_q == SCW'(ST_CYCLES - 1)) begin
          st_res_d = pins_s.st_resp ? `ST_RES_PASS : `ST_RES_FAIL;
          st_done = 1'b1;
          st_state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_state_q <= ST_IDLE;
      st_cnt_q <= '0;
      st_sel_q <= `SEL_RST;
      st_res_q <= `ST_RES_NONE;
    end else begin
      st_state_q <= st_state_d;
      st_cnt_q <= st_cnt_d;
      st_sel_q <= st_sel_d;
      st_res_q <= st_res_d;
    end
  end

  assign st_inject = (st_state_q == ST_RUN);

  // ==========================================================
  // Fault outputs, latch and recovery detect
  fault_out_t fo_q;
  fault_out_t fo_d;
  logic det_prev_q;
  logic det_prev_d;
  logic loop_rst_q;
  logic loop_rst_d;
  logic fault_now;
  logic clear_req;

  // Injected fault during a run drives the latch like a real one
  assign fault_now = pins_s.det || st_inject;
  assign clear_req = !pins_s.clear_n;

  always_comb begin
    fo_d = fo_q;
    fo_d.live = fault_now;
    if (fault_now) begin
      fo_d.latched = 1'b1;
      fo_d.cause = st_inject ? `CAUSE_SELFTEST : (fo_q.cause | pins_s.cause);
    end else if (clear_req) begin
      fo_d.latched = 1'b0;
      fo_d.cause = `CAUSE_NONE;
    end
    if (mask_active) begin
      fo_d = '0;
    end
    det_prev_d = pins_s.det;
    loop_rst_d = det_prev_q && !pins_s.det && !mask_active;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fo_q <= '0;
      det_prev_q <= 1'b0;
      loop_rst_q <= 1'b0;
    end else begin
      fo_q <= fo_d;
      det_prev_q <= det_prev_d;
      loop_rst_q <= loop_rst_d;
    end
  end

  assign live_fault = fo_q.live;
  assign latched_fault_flag = fo_q.latched;
  assign fault_cause_code = fo_q.cause;
  assign loop_reset = loop_rst_q;

  // ==========================================================
  // Interrupt status and mask
  logic [`IRQ_W-1:0] irq_stat_q;
  logic [`IRQ_W-1:0] irq_stat_d;
  logic [`IRQ_W-1:0] irq_mask_q;
  logic [`IRQ_W-1:0] irq_mask_d;
  logic [`IRQ_W-1:0] irq_ev;
  logic [`IRQ_W-1:0] irq_w1c;
  logic irq_q;
  logic irq_d;

  always_comb begin
    irq_ev = '0;
    irq_ev[`IRQ_LATCH] = fo_d.latched && !fo_q.latched;
    irq_ev[`IRQ_ST_DONE] = st_done;
    irq_ev[`IRQ_LOOP_RST] = loop_rst_d;
    irq_w1c = '0;
    if (wr_hit(paddr, `REG_IRQ_STAT, apb_wr)) begin
      irq_w1c = pwdata[`IRQ_W-1:0];
    end
    // New event beats a clear in the same cycle
    irq_stat_d = (irq_stat_q & ~irq_w1c) | irq_ev;
    irq_mask_d = irq_mask_q;
    if (wr_hit(paddr, `REG_IRQ_MASK, apb_wr)) begin
      irq_mask_d = pwdata[`IRQ_W-1:0];
    end
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      irq_q <= irq_d;
    end
  end

  assign irq = irq_q;

  // ==========================================================
  // Read data, captured in the setup cycle
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [31:0] status_word;

  always_comb begin
    status_word = '0;
    status_word[`STS_LIVE] = fo_q.live;
    status_word[`STS_LATCHED] = fo_q.latched;
    status_word[`STS_CAUSE_MSB:`STS_CAUSE_LSB] = fo_q.cause;
    status_word[`STS_MASK] = mask_active;
    status_word[`STS_BUSY] = st_inject;
    status_word[`STS_RES_MSB:`STS_RES_LSB] = st_res_q;
    status_word[`STS_SEL_MSB:`STS_SEL_LSB] = st_sel_q;
  end

  always_comb begin
    prdata_d = prdata_q;
    if (apb_rd_setup) begin
      prdata_d = '0;
      unique case (paddr)
        `REG_CTRL: prdata_d[`CTRL_SEL_MSB:`CTRL_SEL_LSB] = st_sel_q;
        `REG_STATUS: prdata_d = status_word;
        `REG_IRQ_STAT: prdata_d[`IRQ_W-1:0] = irq_stat_q;
        `REG_IRQ_MASK: prdata_d[`IRQ_W-1:0] = irq_mask_q;
        default: prdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;

endmodule : fault_selftest_top
`default_nettype wire

// File: common/fault_regs.svh
// Purpose: Constants for the fault latch and self-test status block.
// Assumes: 32-bit APB, byte addresses, pclk at 10 MHz.
// Notes:   Register offsets, field positions, codes and timing figures.
//
// What this block does
// - Force fault outputs low during mask period.
// - Self-test latched fault held until clear.
// - Failed self-test reports result code 1111.
// - Reserved selection at start reports 1111.
// - Clear strobe resets only latch and cause.
// - Detection independent; recovery resets tracking once.
`ifndef FAULT_REGS_SVH
`define FAULT_REGS_SVH

// ==========================================================
// Register offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0C

// ==========================================================
// Control fields
`define CTRL_START 0
`define CTRL_SEL_LSB 1
`define CTRL_SEL_MSB 3
`define ST_SEL_LAST_VALID 3'h5

// ==========================================================
// Status fields
`define STS_LIVE 0
`define STS_LATCHED 1
`define STS_CAUSE_LSB 2
`define STS_CAUSE_MSB 4
`define STS_MASK 5
`define STS_BUSY 6
`define STS_RES_LSB 8
`define STS_RES_MSB 11
`define STS_SEL_LSB 12
`define STS_SEL_MSB 14

// ==========================================================
// Interrupt bits and width
`define IRQ_W 3
`define IRQ_LATCH 0
`define IRQ_ST_DONE 1
`define IRQ_LOOP_RST 2

// ==========================================================
// Codes and reset values
`define ST_RES_NONE 4'h0
`define ST_RES_PASS 4'h1
`define ST_RES_FAIL 4'hF
`define CAUSE_SELFTEST 3'h7
`define CAUSE_NONE 3'h0
`define SEL_RST 3'h0
`define PINS_RST 6'h20

// ==========================================================
// Timing
`define MASK_TIME_US 70000
`define CLK_PERIOD_NS 100
`define ST_RUN_CYCLES 16

`endif

// File: common/fault_pkg.sv
// Purpose: Types shared by the fault latch and self-test status block.
// Assumes: Included constants from fault_regs.svh.
// Notes:   Pin group and fault output group travel as packed structs.
`default_nettype none
package fault_pkg;

  typedef struct packed {
    logic clear_n;
    logic st_resp;
    logic [2:0] cause;
    logic det;
  } pin_in_t;

  typedef struct packed {
    logic live;
    logic latched;
    logic [2:0] cause;
  } fault_out_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } st_state_t;

endpackage : fault_pkg
`default_nettype wire

// File: logic/in_sync.sv
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Inputs asynchronous to clk.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none
module in_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule : in_sync
`default_nettype wire

// File: bench/fault_host_model.sv
// Purpose: Host model for clear, detector and response pins
// Assumes: Bench commands arrive on pclk
// Notes:   Clear held low HOLD cycles, far over 40 ns
`timescale 1ns/100ps
`default_nettype none
module fault_host_model
  import fault_pkg::*;
#(
  parameter int HOLD = 6
) (
  input wire logic pclk,
  input wire logic clr_go,
  input wire logic det,
  input wire logic [2:0] cause,
  input wire logic resp,
  output var pin_in_t pins
);
  // ======
  // Pin drive
  int cnt = 0;
  initial pins = '{clear_n: 1'b1, default: '0};
  always @(posedge pclk) begin
    cnt <= clr_go ? HOLD : (cnt > 0) ? cnt - 1 : 0;
    pins <= '{clear_n: !(clr_go || cnt > 1), st_resp: resp, cause: cause, det: det};
  end
endmodule : fault_host_model
`default_nettype wire

// File: bench/fault_selftest_checker.sv
// Purpose: Port checks for the fault latch block
// Assumes: One pclk domain
// Notes:   Bound to the top at the foot
`timescale 1ns/100ps
`default_nettype none
module fault_selftest_checker #(
  parameter int MASK_CYCLES = 50
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fault_det_raw,
  input wire logic fault_clear_strobe_n,
  input wire logic live_fault,
  input wire logic latched_fault_flag,
  input wire logic [2:0] fault_cause_code,
  input wire logic loop_reset,
  input wire logic st_inject
);
  // ======
  // Saturating counters; mask surely over at MASK_CYCLES + 3
  int mc_q, mc_d, hi_q, hi_d;
  always_comb begin
    mc_d = (mc_q < MASK_CYCLES + 3) ? mc_q + 1 : mc_q;
    hi_d = !fault_clear_strobe_n ? 0 : (hi_q < 31) ? hi_q + 1 : hi_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_q <= 0;
      hi_q <= 0;
    end else begin
      mc_q <= mc_d;
      hi_q <= hi_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ======
  // Properties
  a_mask_low: assert property (
    mc_q < MASK_CYCLES |-> !live_fault && !latched_fault_flag) else $error("out in mask");
  a_latch_hold: assert property (
    latched_fault_flag && fault_clear_strobe_n && hi_q > 3 |=> latched_fault_flag)
    else $error("latch lost");
  a_st_latches: assert property (
    $fell(st_inject) && mc_q == MASK_CYCLES + 3 && hi_q > 24 |-> latched_fault_flag)
    else $error("run left no latch");
  a_clear_drops: assert property (
    (!fault_clear_strobe_n && !fault_det_raw && !st_inject)[*6]
    |=> !latched_fault_flag && fault_cause_code == 3'h0) else $error("clear ignored");
  a_live_kept: assert property (
    fault_det_raw[*4] ##0 mc_q == MASK_CYCLES + 3 |=> live_fault) else $error("live lost");
  a_loop_pulse: assert property (
    loop_reset |=> !loop_reset) else $error("loop reset long");
  a_loop_recover: assert property (
    fault_det_raw[*3] ##1 !fault_det_raw[*3] ##0 mc_q == MASK_CYCLES + 3
    |-> ##[0:3] loop_reset) else $error("no loop reset");
endmodule : fault_selftest_checker
bind fault_selftest_top fault_selftest_checker #(.MASK_CYCLES(MASK_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .fault_det_raw(fault_det_raw),
  .fault_clear_strobe_n(fault_clear_strobe_n), .live_fault(live_fault),
  .latched_fault_flag(latched_fault_flag), .fault_cause_code(fault_cause_code),
  .loop_reset(loop_reset), .st_inject(st_inject));
`default_nettype wire

// File: bench/test_fault_latch_selftest_status.sv
// Purpose: Self-checking bench for the fault latch block
// Assumes: Mask cut to 50 cycles; seed 15
// Notes:   Random self-test selection and response
`timescale 1ns/100ps
`default_nettype none
`include "fault_regs.svh"
module test_fault_latch_selftest_status
  import fault_pkg::*;
();
  localparam int MASK = 50;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic clr_go = 1'b0, det = 1'b0, resp = 1'b0, pready, pslverr, err;
  logic live_fault, latched_fault_flag, loop_reset, st_inject, irq;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [2:0] cause = 3'h0, fault_cause_code;
  pin_in_t pins;
  int fail_count = 0, cmp_count = 0, seed = 15, i;
  fault_selftest_top #(.MASK_CYCLES(MASK)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_det_raw(pins.det), .fault_cause_raw(pins.cause), .st_resp_raw(pins.st_resp),
    .fault_clear_strobe_n(pins.clear_n), .live_fault(live_fault),
    .latched_fault_flag(latched_fault_flag), .fault_cause_code(fault_cause_code),
    .loop_reset(loop_reset), .st_inject(st_inject), .irq(irq));
  fault_host_model u_host (.pclk(pclk), .clr_go(clr_go), .det(det), .cause(cause),
    .resp(resp), .pins(pins));
  initial begin
    forever #50 pclk = ~pclk;
  end
  // ======
  // Tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk
  task automatic finish_test();
    if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", pready, 1'b1);
    if (pready !== 1'b1) finish_test();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic clear_pin();
    clr_go <= 1'b1;
    @(posedge pclk);
    clr_go <= 1'b0;
    repeat (10) @(posedge pclk);
  endtask : clear_pin
  function automatic logic [3:0] exp_res(input logic [2:0] s, input logic r);
    return (s > `ST_SEL_LAST_VALID || !r) ? `ST_RES_FAIL : `ST_RES_PASS;
  endfunction : exp_res
  task automatic run_st(input logic [2:0] s, input logic r);
    int n;
    resp <= r;
    repeat (4) @(posedge pclk);
    apb(1'b1, `REG_CTRL, 32'({s, 1'b1}));
    n = 0;
    do begin
      apb(1'b0, `REG_STATUS, 32'h0000_0000);
      n++;
    end while (rd[`STS_BUSY] !== 1'b0 && n < 40);
    chk("busy", rd[`STS_BUSY], 1'b0);
    if (rd[`STS_BUSY] !== 1'b0) finish_test();
    chk("result", rd[`STS_RES_MSB:`STS_RES_LSB], exp_res(s, r));
    chk("latch", latched_fault_flag, 1'b1);
  endtask : run_st
  // ======
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    det <= 1'b1;
    cause <= 3'h5;
    repeat (20) @(posedge pclk);
    chk("live", live_fault, 1'b0);
    chk("latch", latched_fault_flag, 1'b0);
    repeat (MASK) @(posedge pclk);
    chk("live", live_fault, 1'b1);
    chk("cause", fault_cause_code, 3'h5);
    det <= 1'b0;
    repeat (10) @(posedge pclk);
    chk("latch", latched_fault_flag, 1'b1);
    clear_pin();
    chk("latch", latched_fault_flag, 1'b0);
    chk("cause", fault_cause_code, 3'h0);
    apb(1'b0, `REG_IRQ_STAT, 32'h0000_0000);
    chk("irq stat", rd, 32'h0000_0005);
    apb(1'b1, `REG_IRQ_MASK, 32'h0000_0007);
    repeat (2) @(posedge pclk);
    chk("irq", irq, 1'b1);
    apb(1'b1, `REG_IRQ_STAT, 32'h0000_0007);
    apb(1'b1, `REG_IRQ_MASK, 32'h0000_0000);
    chk("irq", irq, 1'b0);
    // Forced failure first, then random runs, then both reserved codes
    run_st(3'h2, 1'b0);
    for (i = 0; i < 3; i++) run_st(3'($unsigned($random(seed)) % 6), 1'($random(seed)));
    run_st(3'h6, 1'b1);
    run_st(3'h7, 1'b1);
    chk("irq", irq, 1'b0);
    repeat (20) @(posedge pclk);
    apb(1'b0, `REG_STATUS, 32'h0000_0000);
    chk("result", rd[`STS_RES_MSB:`STS_RES_LSB], `ST_RES_FAIL);
    apb(1'b1, `REG_IRQ_MASK, 32'h0000_0007);
    repeat (2) @(posedge pclk);
    chk("irq", irq, 1'b1);
    clear_pin();
    chk("latch", latched_fault_flag, 1'b0);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("slverr", err, 1'b1);
    chk("rdata", rd, 32'h0000_0000);
    finish_test();
  end
endmodule : test_fault_latch_selftest_status
`default_nettype wire
